// file: rtl/dsls_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - an idle instruction with deep stop selected starts the deep stop entry.
// - the system clock is held 16, 32 or 64 cycles by divide select before it stops.
// - the external clock output goes low between 33 and 46 cycles after the idle.
// - in deep stop peripheral clocks and pll are off, and a crystal oscillator stops.
// - both internal oscillators and the watchdog stay on when their keep bits are set.
// - a falling edge on the wake pin restarts the oscillator and begins wake-up.
// - once the oscillator is stable the pll lock wait allows up to 1 ms.
// - execution resumes within 1125 cycles from sleeping flash or 35 from ram.
// - core clock back on ends deep stop; the wake interrupt, if enabled, is raised when execution resumes.
module dsls_sequencer
    import dsls_pkg::*;
#(
    parameter int unsigned PLL_LOCK_LIMIT = dsls_pkg::PLL_LOCK_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       idleExec,
    input  wire logic       deepStopSel,
    input  wire logic [1:0] clockDivideSelect,
    input  wire logic       crystalSource,
    input  wire logic       keepIntOsc1,
    input  wire logic       keepIntOsc2,
    input  wire logic       keepWatchdog,
    input  wire logic       flashSleep,
    input  wire logic       wakeIntEnable,
    input  wire logic       wakePin_n,
    input  wire logic       externalResetPin_n,
    input  wire logic       oscStable,
    input  wire logic       pllLocked,
    output logic            systemClockOn,
    output logic            externalClockOn,
    output logic            coreClockOn,
    output logic            periphClockOn,
    output logic            pllPowerOn,
    output logic            oscillatorOn,
    output logic            intOsc1On,
    output logic            intOsc2On,
    output logic            watchdogOn,
    output logic            deepStopActive,
    output logic            execResume,
    output logic            wakeIntReq
);
    import dsls_pkg::*;

    localparam logic [CNT_W-1:0] PllLim   = CNT_W'(PLL_LOCK_LIMIT);
    localparam logic [CNT_W-1:0] FlashLim = CNT_W'(RESUME_FLASH_CYC);
    localparam logic [CNT_W-1:0] RamLim   = CNT_W'(RESUME_RAM_CYC);
    localparam logic [5:0]       XclkLim  = 6'(XCLK_LOW_CYC);

    dsls_state_e      state_r;
    dsls_state_e      state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [5:0]       idleCnt_r;
    logic [5:0]       idleCnt_nxt;
    logic             xclkLow_r;
    logic             xclkLow_nxt;
    logic             wakePrev_r;
    logic             wakePrev_nxt;
    logic             execResume_r;
    logic             execResume_nxt;
    logic             wakeInt_r;
    logic             wakeInt_nxt;
    logic [3:0]       syncOut;
    logic             wakeS;
    logic             rstPinS;
    logic             oscStableS;
    logic             pllLockedS;
    logic             wakeEvent;
    logic [CNT_W-1:0] flushLen;
    logic [CNT_W-1:0] resumeLen;

    // pins and analog status come from outside the clock domain
    dsls_sync #(.W(4), .RST_VAL(SYNC_RST)) uSync (
        .clk  (clk),
        .rst  (rst),
        .din  ({pllLocked, oscStable, externalResetPin_n, wakePin_n}),
        .dout (syncOut)
    );
    assign wakeS      = syncOut[0];
    assign rstPinS    = syncOut[1];
    assign oscStableS = syncOut[2];
    assign pllLockedS = syncOut[3];

    // falling edge of the wake pin or a low reset pin; clk stands for the
    // always-on reference, so the async restart is seen two edges late
    assign wakeEvent = (wakePrev_r & ~wakeS) | ~rstPinS;

    always_comb begin
        case (clockDivideSelect)
            2'b10:   flushLen = CNT_W'(FLUSH_CYC_MID);
            2'b11:   flushLen = CNT_W'(FLUSH_CYC_HIGH);
            default: flushLen = CNT_W'(FLUSH_CYC_LOW);
        endcase
        resumeLen = flashSleep ? FlashLim : RamLim;
    end

    always_comb begin
        state_nxt      = state_r;
        cnt_nxt        = cnt_r;
        idleCnt_nxt    = idleCnt_r;
        xclkLow_nxt    = xclkLow_r;
        wakePrev_nxt   = wakeS;
        execResume_nxt = 1'b0;
        wakeInt_nxt    = 1'b0;
        // external clock low is timed from the idle, apart from the flush length
        if (!xclkLow_r && !state_r[0]) begin
            if (idleCnt_r == XclkLim - 6'h01) begin
                xclkLow_nxt = 1'b1;
            end else begin
                idleCnt_nxt = idleCnt_r + 6'h01;
            end
        end
        case (state_r)
            DSLS_RUN: begin
                if (idleExec && deepStopSel) begin
                    state_nxt   = DSLS_FLUSH;
                    cnt_nxt     = CNT_RST;
                    idleCnt_nxt = IDLE_CNT_RST;
                end
            end
            DSLS_FLUSH: begin
                if (cnt_r == flushLen - CNT_W'(1)) begin
                    state_nxt = DSLS_HALT;
                    cnt_nxt   = CNT_RST;
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            DSLS_HALT: begin
                // wake edges seen during flush are lost; the source must wait
                if (wakeEvent) begin
                    state_nxt = DSLS_OSCWAIT;
                end
            end
            DSLS_OSCWAIT: begin
                if (oscStableS) begin
                    state_nxt = DSLS_PLLWAIT;
                    cnt_nxt   = CNT_RST;
                end
            end
            DSLS_PLLWAIT: begin
                // a lock that never comes still ends at the 1 ms allowance
                if (pllLockedS || cnt_r == PllLim - CNT_W'(1)) begin
                    state_nxt = DSLS_RESUME;
                    cnt_nxt   = CNT_RST;
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            DSLS_RESUME: begin
                if (cnt_r == resumeLen - CNT_W'(1)) begin
                    state_nxt      = DSLS_RUN;
                    cnt_nxt        = CNT_RST;
                    execResume_nxt = 1'b1;
                    wakeInt_nxt    = wakeIntEnable;
                    xclkLow_nxt    = 1'b0;
                    idleCnt_nxt    = IDLE_CNT_RST;
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            default: begin
                state_nxt = DSLS_RUN;
                cnt_nxt   = CNT_RST;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r      <= DSLS_RUN;
            cnt_r        <= CNT_RST;
            idleCnt_r    <= IDLE_CNT_RST;
            xclkLow_r    <= 1'b0;
            wakePrev_r   <= 1'b1;
            execResume_r <= 1'b0;
            wakeInt_r    <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            idleCnt_r    <= idleCnt_nxt;
            xclkLow_r    <= xclkLow_nxt;
            wakePrev_r   <= wakePrev_nxt;
            execResume_r <= execResume_nxt;
            wakeInt_r    <= wakeInt_nxt;
        end
    end

    // enables decode straight from the one-hot state flops, the external clock from xclkLow_r
    logic stopped;
    assign stopped         = state_r[2] | state_r[3];
    assign systemClockOn   = state_r[0] | state_r[1] | state_r[5];
    assign coreClockOn     = systemClockOn;
    assign externalClockOn = ~xclkLow_r;
    assign periphClockOn   = state_r[0] | state_r[5];
    assign pllPowerOn      = ~stopped;
    assign oscillatorOn    = ~state_r[2] | ~crystalSource;
    assign intOsc1On       = ~stopped | keepIntOsc1;
    assign intOsc2On       = ~stopped | keepIntOsc2;
    assign watchdogOn      = ~stopped | keepWatchdog;
    assign deepStopActive  = ~state_r[0] & ~state_r[5];
    assign execResume      = execResume_r;
    assign wakeIntReq      = wakeInt_r;

    sequence idleSeq;
        state_r == DSLS_RUN && idleExec && deepStopSel;
    endsequence

    sequence flushDone;
        state_r == DSLS_FLUSH && cnt_r == flushLen - CNT_W'(1);
    endsequence

    idle_entry_a: assert property (@(posedge clk) disable iff (rst)
        idleSeq |=> state_r == DSLS_FLUSH && systemClockOn)
        else $error("idle did not start flush");
    flush_len_a: assert property (@(posedge clk) disable iff (rst)
        state_r == DSLS_HALT && $past(state_r) == DSLS_FLUSH
        |-> $past(cnt_r) == $past(flushLen) - CNT_W'(1) && !systemClockOn)
        else $error("flush length wrong");
    sequence xclkHeld;
        externalClockOn [*8];
    endsequence

    // high through cycle 32 after the idle, low again by cycle 46
    xclk_window_a: assert property (@(posedge clk) disable iff (rst)
        idleSeq |=> xclkHeld ##1 xclkHeld ##1 xclkHeld ##1 xclkHeld
        ##[1:14] !externalClockOn)
        else $error("external clock low outside window");
    halt_gates_a: assert property (@(posedge clk) disable iff (rst)
        state_r == DSLS_HALT |-> !periphClockOn && !pllPowerOn
        && oscillatorOn == !crystalSource)
        else $error("clocks not gated in deep stop");
    keep_alive_a: assert property (@(posedge clk) disable iff (rst)
        state_r == DSLS_HALT |-> intOsc1On == keepIntOsc1
        && intOsc2On == keepIntOsc2 && watchdogOn == keepWatchdog)
        else $error("keep alive mismatch");
    wake_osc_a: assert property (@(posedge clk) disable iff (rst)
        state_r == DSLS_HALT && wakeEvent |=> oscillatorOn && state_r == DSLS_OSCWAIT)
        else $error("wake did not restart oscillator");
    pll_bound_a: assert property (@(posedge clk) disable iff (rst)
        state_r == DSLS_PLLWAIT |-> cnt_r < PllLim)
        else $error("pll wait too long");
    resume_bound_a: assert property (@(posedge clk) disable iff (rst)
        state_r == DSLS_RESUME |-> cnt_r < resumeLen)
        else $error("resume too late");
    wake_int_a: assert property (@(posedge clk) disable iff (rst)
        $past(state_r) == DSLS_RESUME && state_r == DSLS_RUN
        |-> execResume && wakeIntReq == $past(wakeIntEnable) && !deepStopActive)
        else $error("wake interrupt wrong on exit");
    stay_halt_a: assert property (@(posedge clk) disable iff (rst)
        state_r == DSLS_HALT && !wakeEvent |=> state_r == DSLS_HALT)
        else $error("left deep stop without wake");
endmodule : dsls_sequencer

// file: shared/dsls_pkg.sv
package dsls_pkg;
    // system clock
    localparam int unsigned CLK_HZ          = 40_000_000;
    // pll lock allowance, a longest time so it rounds down
    localparam int unsigned PLL_LOCK_MS     = 1;
    localparam int unsigned PLL_LOCK_CYC    = PLL_LOCK_MS * (CLK_HZ / 1000);
    // pipeline flush hold per divide select
    localparam int unsigned FLUSH_CYC_LOW   = 16;
    localparam int unsigned FLUSH_CYC_MID   = 32;
    localparam int unsigned FLUSH_CYC_HIGH  = 64;
    // external clock output stays high for this many cycles after the idle instruction
    localparam int unsigned XCLK_LOW_CYC    = 32;
    // resume after lock
    localparam int unsigned RESUME_FLASH_CYC = 1125;
    localparam int unsigned RESUME_RAM_CYC   = 35;
    localparam int unsigned CNT_W           = 16;
    localparam logic [CNT_W-1:0] CNT_RST    = 16'h0000;
    localparam logic [5:0]  IDLE_CNT_RST    = 6'h00;
    // synchroniser reset levels: wake pins idle high, status low
    localparam logic [3:0]  SYNC_RST        = 4'h3;

    typedef enum logic [5:0] {
        DSLS_RUN     = 6'h01,
        DSLS_FLUSH   = 6'h02,
        DSLS_HALT    = 6'h04,
        DSLS_OSCWAIT = 6'h08,
        DSLS_PLLWAIT = 6'h10,
        DSLS_RESUME  = 6'h20
    } dsls_state_e;
endpackage : dsls_pkg

// file: rtl/dsls_sync.sv
`timescale 1ns/1ps
module dsls_sync #(
    parameter int         W       = 4,
    parameter logic [3:0] RST_VAL = 4'h0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= RST_VAL[W-1:0];
            sync_r <= RST_VAL[W-1:0];
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule : dsls_sync

// file: verification/dsls_wake_source.sv
`timescale 1ns/1ps
module dsls_wake_source #(
    parameter int OSC_START = 6
) (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       useReset,
    input  wire logic [7:0] lockDelay,
    input  wire logic       oscillatorOn,
    input  wire logic       pllPowerOn,
    output logic            wakePin_n,
    output logic            externalResetPin_n,
    output logic            oscStable,
    output logic            pllLocked
);
    int   oscCnt_r = 0;
    int   pllCnt_r = 0;
    int   hold_r   = 0;
    logic lowReq_r = 1'b0;
    logic viaRst_r = 1'b0;
    // pins idle high on pull-ups; oscillator and pll are plain delays
    always @(posedge clk) begin
        oscCnt_r  <= oscillatorOn ? oscCnt_r + 1 : 0;
        pllCnt_r  <= pllPowerOn ? pllCnt_r + 1 : 0;
        oscStable <= oscillatorOn && (oscCnt_r >= OSC_START);
        pllLocked <= pllPowerOn && (pllCnt_r >= int'(lockDelay));
        if (go) begin
            lowReq_r <= 1'b1;
            viaRst_r <= useReset;
            hold_r   <= OSC_START + (useReset ? 8 : 2);
        end else if (hold_r > 0) begin
            hold_r <= hold_r - 1;
        end else if (oscStable) begin
            lowReq_r <= 1'b0;
        end
    end
    // one clean edge each way, a noisy pin may lose later wakes
    assign wakePin_n          = !(lowReq_r && !viaRst_r);
    assign externalResetPin_n = !(lowReq_r && viaRst_r);
endmodule : dsls_wake_source

// file: verification/dsls_sequencer_bench.sv
`timescale 1ns/1ps
module dsls_sequencer_bench;
    import dsls_pkg::*;
    localparam int LOCK_LIM = 20;
    logic clk, rst, idleExec, deepStopSel, crystalSource, flashSleep, wakeIntEnable;
    logic keepIntOsc1, keepIntOsc2, keepWatchdog, go, useReset;
    logic [1:0] clockDivideSelect;
    logic [7:0] lockDelay;
    logic wakePin_n, externalResetPin_n, oscStable, pllLocked;
    logic systemClockOn, externalClockOn, coreClockOn, periphClockOn, pllPowerOn;
    logic oscillatorOn, intOsc1On, intOsc2On, watchdogOn, deepStopActive;
    logic execResume, wakeIntReq;
    int   n_mismatch = 0;
    int   checks     = 0;

    // short lock limit keeps the timeout case quick
    dsls_sequencer #(.PLL_LOCK_LIMIT(LOCK_LIM)) dsls_sequencer_i (
        .clk                (clk),
        .rst                (rst),
        .idleExec           (idleExec),
        .deepStopSel        (deepStopSel),
        .clockDivideSelect  (clockDivideSelect),
        .crystalSource      (crystalSource),
        .keepIntOsc1        (keepIntOsc1),
        .keepIntOsc2        (keepIntOsc2),
        .keepWatchdog       (keepWatchdog),
        .flashSleep         (flashSleep),
        .wakeIntEnable      (wakeIntEnable),
        .wakePin_n          (wakePin_n),
        .externalResetPin_n (externalResetPin_n),
        .oscStable          (oscStable),
        .pllLocked          (pllLocked),
        .systemClockOn      (systemClockOn),
        .externalClockOn    (externalClockOn),
        .coreClockOn        (coreClockOn),
        .periphClockOn      (periphClockOn),
        .pllPowerOn         (pllPowerOn),
        .oscillatorOn       (oscillatorOn),
        .intOsc1On          (intOsc1On),
        .intOsc2On          (intOsc2On),
        .watchdogOn         (watchdogOn),
        .deepStopActive     (deepStopActive),
        .execResume         (execResume),
        .wakeIntReq         (wakeIntReq)
    );
    dsls_wake_source dsls_wake_source_i (
        .clk                (clk),
        .go                 (go),
        .useReset           (useReset),
        .lockDelay          (lockDelay),
        .oscillatorOn       (oscillatorOn),
        .pllPowerOn         (pllPowerOn),
        .wakePin_n          (wakePin_n),
        .externalResetPin_n (externalResetPin_n),
        .oscStable          (oscStable),
        .pllLocked          (pllLocked)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic sc_refuse;
        check({systemClockOn, periphClockOn, pllPowerOn, oscillatorOn}, 4'hF);
        check({intOsc1On, intOsc2On, watchdogOn}, 3'h7);
        deepStopSel = 1'b0;
        idleExec    = 1'b1;
        @(negedge clk);
        idleExec = 1'b0;
        repeat (4) @(negedge clk);
        check({deepStopActive, systemClockOn}, 2'h1);
        deepStopSel = 1'b1;
    endtask : sc_refuse

    task automatic sc_enter(input logic [1:0] div, input logic xtal, input logic [2:0] keep);
        int n;
        int nSys;
        int nExt;
        clockDivideSelect = div;
        crystalSource     = xtal;
        {keepIntOsc1, keepIntOsc2, keepWatchdog} = keep;
        idleExec = 1'b1;
        @(negedge clk);
        idleExec = 1'b0;
        check(deepStopActive, 1'b1);
        nSys = 0;
        nExt = 0;
        for (n = 1; n < 100 && (nSys == 0 || nExt == 0); n++) begin
            if (systemClockOn === 1'b0 && nSys == 0) nSys = n;
            if (externalClockOn === 1'b0 && nExt == 0) nExt = n;
            @(negedge clk);
        end
        if (n >= 100) begin n_mismatch++; test_done; end
        check(16'(nSys), (div == 2'h3) ? 16'h0041 : (div == 2'h2) ? 16'h0021 : 16'h0011);
        check(16'(nExt >= 33 && nExt <= 46), 16'h0001);
        check({coreClockOn, periphClockOn, pllPowerOn, oscillatorOn}, {3'h0, !xtal});
        check({intOsc1On, intOsc2On, watchdogOn}, keep);
    endtask : sc_enter

    task automatic sc_wake(input logic rstPin, input logic flash, input logic intEn,
                           input logic [7:0] lock);
        int n;
        flashSleep    = flash;
        wakeIntEnable = intEn;
        lockDelay     = lock;
        useReset      = rstPin;
        // long quiet spell also keeps the wake source clear of the entry
        repeat (40) @(negedge clk);
        check({deepStopActive, systemClockOn}, 2'h2);
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        for (n = 0; n < 20 && oscillatorOn !== 1'b1; n++) @(negedge clk);
        check(16'(n <= 4), 16'h0001);
        for (n = 0; n < 100 && pllPowerOn !== 1'b1; n++) @(negedge clk);
        check(16'(n < 100), 16'h0001);
        for (n = 0; n < 300 && systemClockOn !== 1'b1; n++) @(negedge clk);
        if (lock > LOCK_LIM)
            check(16'(n >= LOCK_LIM - 1 && n <= LOCK_LIM + 3), 16'h0001);
        else
            check(16'(n > lock && n <= lock + 5), 16'h0001);
        check({deepStopActive, coreClockOn, periphClockOn}, 3'h3);
        for (n = 1; n < 1200 && execResume !== 1'b1; n++) @(negedge clk);
        if (n >= 1200) begin n_mismatch++; test_done; end
        check(16'(n - 1), flash ? 16'h0465 : 16'h0023);
        check({wakeIntReq, externalClockOn}, {intEn, 1'b1});
        @(negedge clk);
    endtask : sc_wake

    initial begin
        {rst, idleExec, deepStopSel, crystalSource, flashSleep, wakeIntEnable} = 6'h21;
        {keepIntOsc1, keepIntOsc2, keepWatchdog, go, useReset} = 5'h00;
        clockDivideSelect = 2'h0;
        lockDelay         = 8'h03;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        sc_refuse;
        for (int i = 0; i < 4; i++) begin
            sc_enter(2'(i), i[0], i[0] ? 3'h5 : 3'h2);
            sc_wake(i[1], i == 1, i[0], 8'h03);
        end
        sc_enter(2'h0, 1'b1, 3'h7);
        sc_wake(1'b0, 1'b0, 1'b1, 8'hC8);
        test_done;
    end
endmodule : dsls_sequencer_bench
